// file: ers_pkg.sv
// package: constants, types and register map of the exposure readout sequencer
package ers_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_EXPO = 8'h04;
    localparam logic [7:0] REG_SIZE = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_FCNT = 8'h10;
    // control field positions
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_LEVEL_BIT = 1;
    localparam int CTRL_DUAL_BIT = 2;
    localparam int CTRL_LANE_LSB = 4;
    // reset values and response codes
    localparam logic [31:0] CTRL_RST = 32'h0000_0010;
    localparam logic [31:0] EXPO_RST = 32'h0000_0064;
    localparam logic [31:0] SIZE_RST = 32'h0004_0010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // correction stages in processing order
    typedef enum logic [2:0] {
        STG_TAP_LIN = 3'h0,
        STG_PHOTO_RESP = 3'h1,
        STG_DEFECT = 3'h2,
        STG_FLAT_FIELD = 3'h3,
        STG_WHITE_BAL = 3'h4,
        STG_GAIN_OFS = 3'h5,
        STG_MIRROR_X = 3'h6
    } ers_stage_t;
    localparam int NUM_STAGES = 7;
    typedef struct packed {
        logic trig_rising;
        logic level_controlled_exposure;
        logic dual_region_geometry;
        logic [2:0] lanes;
    } ers_cfg_t;
    typedef struct packed {
        logic [15:0] width;
        logic [15:0] height;
    } ers_size_t;
endpackage

// file: ers_fifo.sv
// fifo with valid/ready on both sides
`timescale 1ns/1ps
module ers_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and control
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;
    always_comb begin
        in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
        out_valid_o = wp_q != rp_q;
        push = in_valid_i && in_ready_o && ce_i;
        pop = out_valid_o && out_ready_i && ce_i;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        out_data_o = mem_q[rp_q[AW-1:0]];
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// file: ers_top.sv
// exposure, readout and link transfer sequencer with axi4-lite registers
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module ers_top #(
    parameter int PIX_W = 32,
    parameter int FIFO_DEPTH = 8
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // trigger and exposure
    input wire logic external_trigger_input_i,
    output logic expo_active_o,
    // sensor pixel source
    input wire logic [PIX_W-1:0] sensor_pix_i,
    output logic sensor_rd_o,
    // link stream, lane count per beat
    output logic link_valid_o,
    input wire logic link_ready_i,
    output logic [PIX_W-1:0] link_data_o,
    output logic [2:0] link_lanes_o,
    output logic link_sof_o,
    output ers_pkg::ers_stage_t stage_o [ers_pkg::NUM_STAGES],
    // axi4-lite
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_ON = 3'b010,
        EX_HOLD = 3'b100
    } ers_ex_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RUN = 2'b10
    } ers_rd_t;

    // register file
    logic [31:0] ctrl_q, ctrl_d, expo_q, expo_d, size_q, size_d, fcnt_q, fcnt_d;
    logic [7:0] awa_q, awa_d;
    logic aw_has_q, aw_has_d, w_has_q, w_has_d, bv_q, bv_d, rv_q, rv_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [3:0] wstrb_q, wstrb_d;
    ers_pkg::ers_cfg_t cfg;
    ers_pkg::ers_size_t sz;
    logic [31:0] stat;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    always_comb begin
        cfg.trig_rising = ~ctrl_q[ers_pkg::CTRL_EDGE_BIT];
        cfg.level_controlled_exposure = ctrl_q[ers_pkg::CTRL_LEVEL_BIT];
        cfg.dual_region_geometry = ctrl_q[ers_pkg::CTRL_DUAL_BIT];
        cfg.lanes = ctrl_q[ers_pkg::CTRL_LANE_LSB +: 3];
        sz = size_q;
    end

    always_comb begin
        s_awready = !aw_has_q && !bv_q;
        s_wready = !w_has_q && !bv_q;
        s_arready = !rv_q;
        awa_d = awa_q;
        aw_has_d = aw_has_q;
        wd_d = wd_q;
        w_has_d = w_has_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        ctrl_d = ctrl_q;
        expo_d = expo_q;
        size_d = size_q;
        if (s_awvalid && s_awready) begin
            awa_d = s_awaddr;
            aw_has_d = 1'b1;
        end
        if (s_wvalid && s_wready) begin
            wd_d = s_wdata;
            w_has_d = 1'b1;
        end
        if (aw_has_q && w_has_q) begin
            aw_has_d = 1'b0;
            w_has_d = 1'b0;
            bv_d = 1'b1;
            br_d = ers_pkg::RESP_OKAY;
            unique case (awa_q)
                ers_pkg::REG_CTRL: ctrl_d = merge(ctrl_q, wd_q, wstrb_q);
                ers_pkg::REG_EXPO: expo_d = merge(expo_q, wd_q, wstrb_q);
                ers_pkg::REG_SIZE: size_d = merge(size_q, wd_q, wstrb_q);
                ers_pkg::REG_STAT, ers_pkg::REG_FCNT: br_d = ers_pkg::RESP_OKAY;
                default: br_d = ers_pkg::RESP_SLVERR;
            endcase
        end
        if (bv_q && s_bready) bv_d = 1'b0;
        if (s_arvalid && s_arready) begin
            rv_d = 1'b1;
            rr_d = ers_pkg::RESP_OKAY;
            unique case (s_araddr)
                ers_pkg::REG_CTRL: rd_d = ctrl_q;
                ers_pkg::REG_EXPO: rd_d = expo_q;
                ers_pkg::REG_SIZE: rd_d = size_q;
                ers_pkg::REG_STAT: rd_d = stat;
                ers_pkg::REG_FCNT: rd_d = fcnt_q;
                default: begin
                    rd_d = 32'h0000_0000;
                    rr_d = ers_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_rready) begin
            rv_d = 1'b0;
        end
        s_bvalid = bv_q;
        s_bresp = br_q;
        s_rvalid = rv_q;
        s_rresp = rr_q;
        s_rdata = rd_q;
    end

    always_comb wstrb_d = (s_wvalid && s_wready) ? s_wstrb : wstrb_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_q <= ers_pkg::CTRL_RST;
            expo_q <= ers_pkg::EXPO_RST;
            size_q <= ers_pkg::SIZE_RST;
            awa_q <= 8'h00;
            aw_has_q <= 1'b0;
            w_has_q <= 1'b0;
            wd_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rr_q <= 2'h0;
            rd_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            expo_q <= expo_d;
            size_q <= size_d;
            awa_q <= awa_d;
            aw_has_q <= aw_has_d;
            w_has_q <= w_has_d;
            wd_q <= wd_d;
            wstrb_q <= wstrb_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end

    // exposure sequencing
    ers_ex_t ex_q, ex_d;
    ers_rd_t rd_st_q, rd_st_d;
    logic trig_q, start_edge, stop_edge;
    logic [31:0] ecnt_q, ecnt_d;
    logic [15:0] col_q, col_d, row_q, row_d;
    logic rd_start;
    logic fifo_in_ready, fifo_out_valid;
    logic [PIX_W-1:0] fifo_out_data;

    always_comb begin
        start_edge = cfg.trig_rising ? (external_trigger_input_i && !trig_q) : (!external_trigger_input_i && trig_q);
        stop_edge = cfg.trig_rising ? (!external_trigger_input_i && trig_q) : (external_trigger_input_i && !trig_q);
        ex_d = ex_q;
        ecnt_d = ecnt_q;
        rd_start = 1'b0;
        unique case (ex_q)
            EX_IDLE: begin
                // a new exposure is accepted whatever readout is doing
                if (start_edge) begin
                    ex_d = EX_ON;
                    ecnt_d = 32'h0000_0001;
                end
            end
            EX_ON: begin
                // start edges are not looked at here
                ecnt_d = ecnt_q + 32'h0000_0001;
                if (cfg.level_controlled_exposure ? stop_edge : (ecnt_q >= expo_q)) begin
                    ex_d = EX_HOLD;
                end
            end
            EX_HOLD: begin
                if (rd_st_q == RD_IDLE) begin
                    rd_start = 1'b1;
                    ex_d = EX_IDLE;
                end
            end
            default: ex_d = EX_IDLE;
        endcase
        expo_active_o = ex_q == EX_ON;
    end

    // readout of width*height pixels into the frame buffer
    always_comb begin
        rd_st_d = rd_st_q;
        col_d = col_q;
        row_d = row_q;
        fcnt_d = fcnt_q;
        sensor_rd_o = (rd_st_q == RD_RUN) && fifo_in_ready;
        unique case (rd_st_q)
            RD_IDLE: begin
                if (rd_start) begin
                    rd_st_d = RD_RUN;
                    col_d = 16'h0000;
                    row_d = 16'h0000;
                end
            end
            RD_RUN: begin
                if (sensor_rd_o) begin
                    col_d = col_q + 16'h0001;
                    if (col_q + 16'h0001 >= sz.width) begin
                        col_d = 16'h0000;
                        row_d = row_q + 16'h0001;
                        if (row_q + 16'h0001 >= sz.height) begin
                            rd_st_d = RD_IDLE;
                            fcnt_d = fcnt_q + 32'h0000_0001;
                        end
                    end
                end
            end
            default: rd_st_d = RD_IDLE;
        endcase
        stat = {27'h0000000, cfg.dual_region_geometry, rd_st_q == RD_RUN, ex_q == EX_HOLD, expo_active_o, trig_q};
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ex_q <= EX_IDLE;
            rd_st_q <= RD_IDLE;
            // follow the pin during reset so no false start edge follows release
            trig_q <= external_trigger_input_i;
            ecnt_q <= 32'h0000_0000;
            col_q <= 16'h0000;
            row_q <= 16'h0000;
            fcnt_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ex_q <= ex_d;
            rd_st_q <= rd_st_d;
            trig_q <= external_trigger_input_i;
            ecnt_q <= ecnt_d;
            col_q <= col_d;
            row_q <= row_d;
            fcnt_q <= fcnt_d;
        end
    end

    // frame buffer; link drains it while readout still fills it
    ers_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fbuf (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .in_valid_i(sensor_rd_o),
        .in_ready_o(fifo_in_ready),
        .in_data_i(sensor_pix_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(link_ready_i),
        .out_data_o(fifo_out_data)
    );

    always_comb begin
        link_valid_o = fifo_out_valid;
        link_data_o = fifo_out_data;
        link_lanes_o = cfg.lanes; // beat rate of partner scales with lanes
        link_sof_o = rd_start;
        for (int i = 0; i < ers_pkg::NUM_STAGES; i++) begin
            stage_o[i] = ers_pkg::ers_stage_t'(i[2:0]);
        end
    end

    chk_expo_win_end: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && ex_q == EX_ON && ex_d == EX_HOLD) |=> !expo_active_o)
        else $error("exposure output stayed high");
    chk_trig_ignored: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && expo_active_o && start_edge) |=> ex_q != EX_IDLE)
        else $error("trigger restarted exposure");
    chk_rd_single: assert property (@(posedge mclk_i) disable iff (srst_i)
        rd_start |-> rd_st_q == RD_IDLE)
        else $error("readout restarted early");
    chk_timed_end: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && ex_q == EX_ON && !cfg.level_controlled_exposure && ecnt_q >= expo_q) |=> ex_q == EX_HOLD)
        else $error("timed exposure overran");
    chk_start_on: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && ex_q == EX_IDLE && start_edge) |=> expo_active_o)
        else $error("trigger not accepted");
    chk_rd_follows: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && ex_q == EX_HOLD && rd_st_q == RD_IDLE) |=> rd_st_q == RD_RUN)
        else $error("readout did not follow exposure");
endmodule

// file: ers_grabber.sv
// frame grabber model: stream sink that can stall or take every other beat
`timescale 1ns/1ps
module ers_grabber (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // behaviour
    input wire logic stall_i,
    input wire logic slow_i,
    // stream
    input wire logic link_valid_i,
    output logic link_ready_o,
    output int beats_o
);
    logic tog_q;
    always_ff @(posedge mclk_i) begin
        tog_q <= srst_i ? 1'b0 : !tog_q;
        if (srst_i)
            beats_o <= 0;
        else if (link_valid_i && link_ready_o)
            beats_o <= beats_o + 1;
    end
    // ready does not wait on valid; a slow grabber accepts on alternate cycles
    assign link_ready_o = !stall_i && (!slow_i || tog_q);
endmodule

// file: exposure_readout_sequencer_tb.sv
// self-checking testbench of the exposure readout sequencer
`timescale 1ns/1ps
module exposure_readout_sequencer_tb;
    logic mclk_i = 0, srst_i = 1, trig = 0, stall = 0, slow = 0, ce = 1;
    logic [31:0] pix = 0, ldata, wdata = 0, rdata;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic expo, rd, lv, lr, sof, awr, wr, bv, arr, rv;
    logic [2:0] lanes, lanes_seen = 0;
    logic [1:0] bresp, rresp;
    ers_pkg::ers_stage_t stg [ers_pkg::NUM_STAGES];
    int miscompares = 0, n_checks = 0, beats, run = 0, last_len = 0, n_expo = 0, rd_cnt = 0, ovl = 0, both = 0;
    int n_sof = 0, bad_data = 0;

    always #5 mclk_i = ~mclk_i;

    ers_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce),
        .external_trigger_input_i(trig), .expo_active_o(expo), .sensor_pix_i(pix), .sensor_rd_o(rd),
        .link_valid_o(lv), .link_ready_i(lr), .link_data_o(ldata), .link_lanes_o(lanes), .link_sof_o(sof),
        .stage_o(stg), .s_awaddr(awaddr), .s_awvalid(awv), .s_awready(awr), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wv), .s_wready(wr), .s_bresp(bresp), .s_bvalid(bv), .s_bready(br),
        .s_araddr(araddr), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rv), .s_rready(rr));

    ers_grabber grab (.mclk_i(mclk_i), .srst_i(srst_i), .stall_i(stall), .slow_i(slow),
        .link_valid_i(lv), .link_ready_o(lr), .beats_o(beats));

    // pixel source and activity monitor
    always @(posedge mclk_i) begin
        pix <= pix + {31'h0, rd};
        rd_cnt <= rd_cnt + int'(rd);
        n_sof <= n_sof + int'(sof);
        // the k-th beat on the link must carry the k-th pixel read
        if (lv && lr && ldata !== beats)
            bad_data <= bad_data + 1;
        if (expo)
            run <= run + 1;
        else if (run != 0) begin
            last_len <= run;
            run <= 0;
            n_expo <= n_expo + 1;
        end
        if (expo && rd)
            ovl <= ovl + 1;
        if (rd && lv && lr)
            both <= both + 1;
        if (lv && lr)
            lanes_seen <= lanes;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic timeout(input string nm);
        miscompares++;
        $display("ERROR %s expected done seen timeout", nm);
        complete_run();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic set_trig(input logic v, input int n);
        @(posedge mclk_i);
        trig <= v;
        tick(n);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk_i);
            if (awv && awr)
                awv <= 0;
            if (wv && wr)
                wv <= 0;
            if (bv)
                break;
        end
        br <= 0;
        if (n == 100)
            timeout("bvalid");
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk_i);
        araddr <= a;
        arv <= 1;
        rr <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge mclk_i);
            if (arv && arr)
                arv <= 0;
            if (rv) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        rr <= 0;
        if (n == 100)
            timeout("rvalid");
    endtask

    // idle means no exposure, no readout and no pending link data for 20 cycles
    task automatic wait_idle;
        int n, q;
        q = 0;
        for (n = 0; n < 3000 && q < 20; n++) begin
            @(posedge mclk_i);
            q = (expo || rd || lv) ? 0 : q + 1;
        end
        if (q < 20)
            timeout("idle");
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(ers_pkg::REG_CTRL, d, r);
        chk("ctrl_reset", ers_pkg::CTRL_RST, d);
        axi_rd(ers_pkg::REG_EXPO, d, r);
        chk("expo_reset", ers_pkg::EXPO_RST, d);
        axi_rd(ers_pkg::REG_SIZE, d, r);
        chk("size_reset", ers_pkg::SIZE_RST, d);
        axi_rd(8'h20, d, r);
        chk("unmapped_resp", {30'h0, ers_pkg::RESP_SLVERR}, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        axi_wr(ers_pkg::REG_EXPO, 32'h14);
        axi_rd(ers_pkg::REG_EXPO, d, r);
        chk("expo_readback", 32'h14, d);
        for (int i = 0; i < ers_pkg::NUM_STAGES; i++)
            chk("stage_order", i, stg[i]);
        $display("t_regs done");
    endtask

    // timed rising-edge exposure of 20 cycles, a second edge mid-exposure
    task automatic t_timed;
        logic [31:0] d, f;
        logic [1:0] r;
        int e0, r0, b0, s0;
        axi_wr(ers_pkg::REG_SIZE, 32'h0002_0004);
        axi_rd(ers_pkg::REG_FCNT, f, r);
        e0 = n_expo;
        r0 = rd_cnt;
        b0 = beats;
        s0 = n_sof;
        set_trig(1, 5);
        set_trig(0, 5);
        set_trig(1, 3);
        set_trig(0, 1);
        wait_idle();
        chk("exposures", e0 + 1, n_expo);
        chk("expo_len_20_21", 1, last_len >= 20 && last_len <= 21);
        chk("pixels_read", r0 + 8, rd_cnt);
        chk("beats_sent", b0 + 8, beats);
        chk("sof_pulses", s0 + 1, n_sof);
        chk("link_data", 0, bad_data);
        axi_rd(ers_pkg::REG_FCNT, d, r);
        chk("frame_count", f + 1, d);
        $display("t_timed done");
    endtask

    // falling edge, level controlled: 13 cycles low
    task automatic t_level;
        int e0;
        axi_wr(ers_pkg::REG_CTRL, 32'h13);
        e0 = n_expo;
        set_trig(1, 8);
        set_trig(0, 12);
        set_trig(1, 2);
        wait_idle();
        chk("exposures", e0 + 1, n_expo);
        chk("expo_len_12_13", 1, last_len >= 12 && last_len <= 13);
        $display("t_level done");
    endtask

    // second exposure starts while the first frame is still read and sent
    task automatic t_overlap;
        int e0, r0, b0, o0, c0;
        axi_wr(ers_pkg::REG_CTRL, 32'h44);
        axi_wr(ers_pkg::REG_EXPO, 32'h4);
        axi_wr(ers_pkg::REG_SIZE, 32'h0004_0004);
        slow <= 1;
        set_trig(0, 2);
        e0 = n_expo;
        r0 = rd_cnt;
        b0 = beats;
        o0 = ovl;
        c0 = both;
        set_trig(1, 2);
        set_trig(0, 10);
        set_trig(1, 2);
        set_trig(0, 1);
        wait_idle();
        chk("exposures", e0 + 2, n_expo);
        chk("expo_during_readout", 1, ovl > o0);
        chk("pixels_read", r0 + 32, rd_cnt);
        chk("beats_sent", b0 + 32, beats);
        chk("read_while_send", 1, both > c0);
        chk("lanes", 3'h4, lanes_seen);
        slow <= 0;
        $display("t_overlap done");
    endtask

    // grabber stalls: buffer fills and refuses, then drains to empty
    task automatic t_fifo;
        int r0, b0;
        r0 = rd_cnt;
        b0 = beats;
        stall <= 1;
        set_trig(1, 2);
        set_trig(0, 60);
        chk("stalled_valid", 1, lv);
        chk("reads_held_back", r0 + 8, rd_cnt);
        chk("stalled_beats", b0, beats);
        stall <= 0;
        wait_idle();
        chk("beats_sent", b0 + 16, beats);
        chk("pixels_read", r0 + 16, rd_cnt);
        chk("link_data", 0, bad_data);
        $display("t_fifo done");
    endtask

    // clock enable low for 10 cycles stretches a 4-cycle timed exposure to 14
    task automatic t_freeze;
        int e0;
        e0 = n_expo;
        set_trig(1, 1);
        ce <= 0;
        tick(10);
        ce <= 1;
        set_trig(0, 1);
        wait_idle();
        chk("exposures", e0 + 1, n_expo);
        chk("expo_len_frozen", 14, last_len);
        $display("t_freeze done");
    endtask

    initial begin
        tick(5);
        srst_i <= 0;
        t_regs();
        t_timed();
        t_level();
        t_overlap();
        t_fifo();
        t_freeze();
        complete_run();
    end
endmodule
